//--- src/clb_status.sv
// Current loop block status: gathers hold-off conditions into a 16-bit status
// word, blocks the current controller while any is set, APB registers, interrupt.
// Assumes condition pins are asynchronous levels; drive request and fault
// enable come from logic on clk_sys.
//
// Overview of operation
// - Any status bit set blocks controller, zero current reference, firing angle at limit.
// - Bits 0,1,2: armature overcurrent, mains overvoltage, mains undervoltage.
// - Bit 3: waiting for back-EMF to fall to match mains voltage.
// - Bits 6 and 8: field exciter self-test failed, motor 1 or 2.
// - Bits 7 and 9: field exciter ready lost, motor 1 or 2.
// - Bit 10: waiting for armature current to reach zero.
// - Bit 11: field reversal in progress, controller held blocked.
// - Bit 13: release withheld, phase-lock deviation limit reached.
// - Bit 14: mains out of synchronism.
// - Bit 15: relevant fault or level 3 alarm, controller not released.
// - Set bit alone raises no fault message; drive state must allow it.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "clb_regs.svh"
module clb_status (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire clb_pkg::clb_cond_t condPin,
  input  wire clb_pkg::clb_drive_t driveReq,
  input  wire logic               driveFaultEnable,
  output clb_pkg::clb_drive_t     driveApplied,
  output logic                    ctrlBlock,
  output logic                    faultMessage,
  output logic                    irq
);

  // ************************************************************
  // Condition synchronisation
  // ************************************************************
  logic [$bits(clb_pkg::clb_cond_t)-1:0] condSyncBits;
  clb_pkg::clb_cond_t                    cond;

  clb_sync #(
    .WIDTH ($bits(clb_pkg::clb_cond_t))
  ) u_cond_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (condPin),
    .dout    (condSyncBits)
  );

  assign cond = clb_pkg::clb_cond_t'(condSyncBits);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [15:0]        status_d;
  logic [15:0]        status_q;
  logic [15:0]        irqStat_d;
  logic [15:0]        irqStat_q;
  logic [15:0]        irqMask_q;
  clb_pkg::clb_mode_t mode_q;
  logic [15:0]        alphaLim_q;
  logic [15:0]        blockCnt_q;
  logic [15:0]        firstCause_q;
  logic               block_d;
  logic               wrAccess;
  logic               rdSetup;
  logic               addrHit;
  logic [1:0]         settleCnt_q;
  logic               settled;

  // ************************************************************
  // Status word assembly
  // ************************************************************
  always_comb begin
    status_d = `CLB_STATUS_RST;
    status_d[`CLB_B_ARM_OVERCUR]   = cond.armOverCur;
    status_d[`CLB_B_MAINS_OVERV]   = cond.mainsOverVolt;
    status_d[`CLB_B_MAINS_UNDERV]  = cond.mainsUnderVolt;
    status_d[`CLB_B_EMF_WAIT]      = cond.emfWait;
    status_d[`CLB_B_REV_FAULT]     = cond.reversalFault;
    unique case (mode_q)
      clb_pkg::CLB_MODE_SINGLE: begin
        status_d[`CLB_B_MODE_DEP] = 1'b0;
      end
      clb_pkg::CLB_MODE_TWELVE_PULSE: begin
        status_d[`CLB_B_MODE_DEP] = cond.partnerBlocked;
      end
      clb_pkg::CLB_MODE_FIELD_SUPPLY: begin
        status_d[`CLB_B_MODE_DEP] = cond.overVoltProt;
      end
    endcase
    status_d[`CLB_B_M1_FEX_TEST]   = cond.m1FexTestFail;
    status_d[`CLB_B_M2_FEX_TEST]   = cond.m2FexTestFail;
    status_d[`CLB_B_M1_FEX_RDY]    = cond.m1FexNotReady;
    status_d[`CLB_B_M2_FEX_RDY]    = cond.m2FexNotReady;
    status_d[`CLB_B_ZERO_CUR_WAIT] = cond.zeroCurWait;
    status_d[`CLB_B_FIELD_REV]     = cond.fieldReversal;
    status_d[`CLB_B_UNUSED]        = 1'b0;
    status_d[`CLB_B_PLL_LIMIT]     = cond.pllDevLimit;
    status_d[`CLB_B_MAINS_NOSYNC]  = cond.mainsNotSync;
    status_d[`CLB_B_NOT_RELEASED]  = cond.relevantFault
      | (cond.alarmActive & (cond.alarmLevel == `CLB_ALARM_LEVEL_BLOCK));
  end

  // Bit 12 is held zero above, so the OR cannot see it
  assign block_d = |status_d;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_q <= `CLB_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // ************************************************************
  // Start-up hold
  // ************************************************************
  // The synchroniser restarts from zero, so its first two outputs after
  // reset are not real samples; keep the controller blocked until they are
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settleCnt_q <= `CLB_SETTLE_RST;
    end else if (!settled) begin
      settleCnt_q <= settleCnt_q + `CLB_SETTLE_ONE;
    end
  end

  assign settled = (settleCnt_q == `CLB_SETTLE_DONE);

  // ************************************************************
  // Controller blocking
  // ************************************************************
  // Status and the forced outputs move on the same edge, so software
  // never sees a set bit while the reference still passes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrlBlock                <= 1'b1;
      driveApplied.currentRef  <= `CLB_REF_ZERO;
      driveApplied.firingAngle <= `CLB_ALPHA_LIM_RST;
    end else if (block_d || !settled) begin
      ctrlBlock                <= 1'b1;
      driveApplied.currentRef  <= `CLB_REF_ZERO;
      driveApplied.firingAngle <= alphaLim_q;
    end else begin
      ctrlBlock                <= 1'b0;
      driveApplied.currentRef  <= driveReq.currentRef;
      driveApplied.firingAngle <= driveReq.firingAngle;
    end
  end

  // ************************************************************
  // Fault message gating
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      faultMessage <= 1'b0;
    end else begin
      faultMessage <= block_d & driveFaultEnable;
    end
  end

  // ************************************************************
  // Diagnostics: block count and first cause
  // ************************************************************
  // Counter saturates rather than wraps, so a stuck drive reads as busy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blockCnt_q <= `CLB_COUNT_RST;
    end else if (block_d && !ctrlBlock && blockCnt_q != `CLB_COUNT_MAX) begin
      blockCnt_q <= blockCnt_q + `CLB_COUNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      firstCause_q <= `CLB_STATUS_RST;
    end else if (block_d && !ctrlBlock) begin
      firstCause_q <= status_d;
    end
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  // Zero wait states: every access phase ends in its first cycle
  assign wrAccess = psel & penable & pwrite;
  assign rdSetup  = psel & ~penable;
  assign pready   = psel & penable;

  always_comb begin
    unique case (paddr)
      `CLB_ADDR_STATUS,
      `CLB_ADDR_IRQ_STAT,
      `CLB_ADDR_IRQ_MASK,
      `CLB_ADDR_MODE,
      `CLB_ADDR_ALPHA_LIM,
      `CLB_ADDR_APPLIED,
      `CLB_ADDR_BLOCK_CNT,
      `CLB_ADDR_FIRST_CAUSE: begin
        addrHit = 1'b1;
      end
      default: begin
        addrHit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Writable registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqMask_q <= `CLB_IRQ_MASK_RST;
    end else if (wrAccess && paddr == `CLB_ADDR_IRQ_MASK) begin
      irqMask_q <= pwdata[`CLB_WORD_MSB:0];
    end
  end

  // Illegal mode codes are dropped so the mode stays decodable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_q <= clb_pkg::CLB_MODE_SINGLE;
    end else if (wrAccess && paddr == `CLB_ADDR_MODE
                 && pwdata[`CLB_MODE_MSB:0] <= clb_pkg::CLB_MODE_FIELD_SUPPLY) begin
      mode_q <= clb_pkg::clb_mode_t'(pwdata[`CLB_MODE_MSB:0]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alphaLim_q <= `CLB_ALPHA_LIM_RST;
    end else if (wrAccess && paddr == `CLB_ADDR_ALPHA_LIM) begin
      alphaLim_q <= pwdata[`CLB_WORD_MSB:0];
    end
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // A new rising edge wins over a write-one-to-clear in the same cycle
  always_comb begin
    irqStat_d = irqStat_q;
    if (wrAccess && paddr == `CLB_ADDR_IRQ_STAT) begin
      irqStat_d = irqStat_d & ~pwdata[`CLB_WORD_MSB:0];
    end
    irqStat_d = irqStat_d | (status_d & ~status_q);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irqStat_q <= `CLB_STATUS_RST;
    end else begin
      irqStat_q <= irqStat_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStat_d & irqMask_q);
    end
  end

  // ************************************************************
  // Read data and error, captured in the setup cycle
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= `CLB_PRDATA_ZERO;
    end else if (rdSetup) begin
      prdata <= `CLB_PRDATA_ZERO;
      if (!pwrite) begin
        unique case (paddr)
          `CLB_ADDR_STATUS:      prdata[`CLB_WORD_MSB:0] <= status_q;
          `CLB_ADDR_IRQ_STAT:    prdata[`CLB_WORD_MSB:0] <= irqStat_q;
          `CLB_ADDR_IRQ_MASK:    prdata[`CLB_WORD_MSB:0] <= irqMask_q;
          `CLB_ADDR_MODE:        prdata[`CLB_MODE_MSB:0] <= mode_q;
          `CLB_ADDR_ALPHA_LIM:   prdata[`CLB_WORD_MSB:0] <= alphaLim_q;
          `CLB_ADDR_APPLIED:     prdata <= driveApplied;
          `CLB_ADDR_BLOCK_CNT:   prdata[`CLB_WORD_MSB:0] <= blockCnt_q;
          `CLB_ADDR_FIRST_CAUSE: prdata[`CLB_WORD_MSB:0] <= firstCause_q;
          default:               prdata <= `CLB_PRDATA_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pslverr <= 1'b0;
    end else if (rdSetup) begin
      pslverr <= ~addrHit;
    end
  end

endmodule : clb_status

//--- src/clb_regs.svh
// Register map, field positions and reset values of the current loop block status unit.
// Assumes inclusion by bare name from files that also use the clb_pkg types.
`ifndef CLB_REGS_SVH
`define CLB_REGS_SVH

// ************************************************************
// Register byte addresses (APB, one aligned word each)
// ************************************************************
`define CLB_ADDR_STATUS      8'h00
`define CLB_ADDR_IRQ_STAT    8'h04
`define CLB_ADDR_IRQ_MASK    8'h08
`define CLB_ADDR_MODE        8'h0C
`define CLB_ADDR_ALPHA_LIM   8'h10
`define CLB_ADDR_APPLIED     8'h14
`define CLB_ADDR_BLOCK_CNT   8'h18
`define CLB_ADDR_FIRST_CAUSE 8'h1C

// ************************************************************
// Status word bit positions
// ************************************************************
`define CLB_B_ARM_OVERCUR    0
`define CLB_B_MAINS_OVERV    1
`define CLB_B_MAINS_UNDERV   2
`define CLB_B_EMF_WAIT       3
`define CLB_B_REV_FAULT      4
`define CLB_B_MODE_DEP       5
`define CLB_B_M1_FEX_TEST    6
`define CLB_B_M1_FEX_RDY     7
`define CLB_B_M2_FEX_TEST    8
`define CLB_B_M2_FEX_RDY     9
`define CLB_B_ZERO_CUR_WAIT  10
`define CLB_B_FIELD_REV      11
`define CLB_B_UNUSED         12
`define CLB_B_PLL_LIMIT      13
`define CLB_B_MAINS_NOSYNC   14
`define CLB_B_NOT_RELEASED   15

// ************************************************************
// Field layout and reset values
// ************************************************************
`define CLB_WORD_MSB         15
`define CLB_MODE_MSB         1
`define CLB_STATUS_RST       16'h0000
`define CLB_IRQ_MASK_RST     16'h0000
`define CLB_ALPHA_LIM_RST    16'h0096
`define CLB_COUNT_RST        16'h0000
`define CLB_COUNT_MAX        16'hFFFF
`define CLB_COUNT_ONE        16'h0001
`define CLB_REF_ZERO         16'h0000
`define CLB_PRDATA_ZERO      32'h0000_0000
`define CLB_ALARM_LEVEL_BLOCK 2'h3
`define CLB_SETTLE_RST       2'h0
`define CLB_SETTLE_ONE       2'h1
`define CLB_SETTLE_DONE      2'h2

`endif

//--- src/clb_pkg.sv
// Types shared by the current loop block status unit.
// Assumes the offsets and bit positions come from clb_regs.svh.
package clb_pkg;

  // ************************************************************
  // Operating mode
  // ************************************************************
  typedef enum logic [1:0] {
    CLB_MODE_SINGLE,
    CLB_MODE_TWELVE_PULSE,
    CLB_MODE_FIELD_SUPPLY
  } clb_mode_t;

  // ************************************************************
  // Condition inputs from protection and supervision
  // ************************************************************
  typedef struct packed {
    logic       armOverCur;
    logic       mainsOverVolt;
    logic       mainsUnderVolt;
    logic       emfWait;
    logic       reversalFault;
    logic       partnerBlocked;
    logic       overVoltProt;
    logic       m1FexTestFail;
    logic       m1FexNotReady;
    logic       m2FexTestFail;
    logic       m2FexNotReady;
    logic       zeroCurWait;
    logic       fieldReversal;
    logic       pllDevLimit;
    logic       mainsNotSync;
    logic       relevantFault;
    logic       alarmActive;
    logic [1:0] alarmLevel;
  } clb_cond_t;

  // ************************************************************
  // Current reference and firing angle pair
  // ************************************************************
  typedef struct packed {
    logic [15:0] currentRef;
    logic [15:0] firingAngle;
  } clb_drive_t;

endpackage : clb_pkg

//--- src/clb_sync.sv
// Two flip-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level; no multi-bit coherence is given.
`timescale 1ns/1ps
module clb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_q <= '0;
      dout     <= '0;
    end else begin
      stage1_q <= din;
      dout     <= stage1_q;
    end
  end

endmodule : clb_sync

//--- bench/clb_status_chk.sv
// Checker for the current loop block status unit, bound to its top ports.
// Assumes one clock, synchronous active-high reset, two-stage pin sync.
`timescale 1ns/1ps
module clb_status_chk (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire clb_pkg::clb_cond_t  condPin,
  input wire clb_pkg::clb_drive_t driveReq,
  input wire logic                driveFaultEnable,
  input wire clb_pkg::clb_drive_t driveApplied,
  input wire logic                ctrlBlock,
  input wire logic                faultMessage,
  input wire logic                irq
);
  // ********************
  // Helpers
  // ********************
  // Bit 5 depends on the mode register, which is not visible here
  logic coreAny;
  logic noneAny;
  assign coreAny = (|condPin[18:14]) || (|condPin[11:3])
                   || (condPin.alarmActive && condPin.alarmLevel == 2'h3);
  assign noneAny = !coreAny && !condPin.partnerBlocked && !condPin.overVoltProt;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_settled;
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3);
  endsequence
  sequence s_setup_rd0;
    psel && !penable && !pwrite && paddr == 8'h00;
  endsequence
  sequence s_setup_bad;
    psel && !penable && paddr > 8'h1C;
  endsequence

  // ********************
  // Assertions
  // ********************
  a_block_on_cause: assert property (s_settled ##0 $past(coreAny, 3) |->
    ctrlBlock && driveApplied.currentRef == 16'h0000) else $error("no block on cause");
  a_release_when_clear: assert property (s_settled ##0 $past(noneAny, 3) |->
    !ctrlBlock) else $error("block without cause");
  a_ref_forced_zero: assert property (ctrlBlock |->
    driveApplied.currentRef == 16'h0000) else $error("reference not zero");
  a_fault_needs_enable: assert property (faultMessage |->
    $past(driveFaultEnable)) else $error("fault without enable");
  a_fault_needs_block: assert property (faultMessage |-> ctrlBlock)
    else $error("fault without status");
  a_fault_raised: assert property (s_settled ##0 $past(coreAny, 3)
    && $past(driveFaultEnable) |-> faultMessage) else $error("fault missing");
  a_ready_zero_wait: assert property (pready == (psel && penable))
    else $error("pready wrong");
  a_slverr_unmapped: assert property (s_setup_bad |=> pslverr
    && prdata == 32'h0000_0000) else $error("unmapped not refused");
  a_status_upper_zero: assert property (s_setup_rd0 |=>
    prdata[31:16] == 16'h0000 && !prdata[12]) else $error("status spare bits set");
  a_hold_after_reset: assert property ($fell(rst) |->
    ctrlBlock ##1 ctrlBlock ##1 ctrlBlock) else $error("block dropped after reset");
endmodule : clb_status_chk

bind clb_status clb_status_chk chk_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .condPin(condPin), .driveReq(driveReq),
  .driveFaultEnable(driveFaultEnable), .driveApplied(driveApplied),
  .ctrlBlock(ctrlBlock), .faultMessage(faultMessage), .irq(irq));

//--- bench/clb_status_bench.sv
// Self-checking bench for the current loop block status unit.
// Assumes zero-wait APB and a five-edge settle from pin to register read.
`timescale 1ns/1ps
`include "clb_regs.svh"
module clb_status_bench;
  typedef struct {int idx; int mode; logic [1:0] lvl; logic [15:0] exp;} clb_row_t;
  logic                clk_sys = 1'b0;
  logic                rst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  clb_pkg::clb_cond_t  condPin = '0;
  clb_pkg::clb_drive_t driveReq = 32'h1234_0040;
  logic                driveFaultEnable = 1'b0;
  clb_pkg::clb_drive_t driveApplied;
  logic                ctrlBlock;
  logic                faultMessage;
  logic                irq;
  int                  err_total = 0;
  int                  cmp_count = 0;
  int                  nBlk = 0;
  logic [31:0]         rd;
  logic                err;
  logic                blk;
  logic [15:0]         lastCause;
  logic [$bits(clb_pkg::clb_cond_t)-1:0] cv;
  // Field index counts from the struct's first field; level sits in the low bits
  clb_row_t rows [20] = '{'{0,0,0,16'h0001}, '{1,0,0,16'h0002}, '{2,0,0,16'h0004},
    '{3,0,0,16'h0008}, '{4,0,0,16'h0010}, '{5,1,0,16'h0020}, '{5,2,0,16'h0000},
    '{6,2,0,16'h0020}, '{6,0,0,16'h0000}, '{7,0,0,16'h0040}, '{8,0,0,16'h0080},
    '{9,0,0,16'h0100}, '{10,0,0,16'h0200}, '{11,0,0,16'h0400}, '{12,0,0,16'h0800},
    '{13,0,0,16'h2000}, '{14,0,0,16'h4000}, '{15,0,0,16'h8000}, '{16,0,3,16'h8000},
    '{16,0,2,16'h0000}};

  clb_status dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .condPin(condPin), .driveReq(driveReq),
    .driveFaultEnable(driveFaultEnable), .driveApplied(driveApplied),
    .ctrlBlock(ctrlBlock), .faultMessage(faultMessage), .irq(irq));

  always #25 clk_sys = ~clk_sys;

  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Idle edge after each transfer keeps one assignment per signal per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b1, `CLB_ADDR_IRQ_MASK, 32'h0000_FFFF);
    foreach (rows[i]) begin
      apb(1'b1, `CLB_ADDR_MODE, 32'(rows[i].mode));
      driveFaultEnable <= i[0];
      cv = '0;
      cv[$bits(cv) - 1 - rows[i].idx] = 1'b1;
      cv[1:0] = rows[i].lvl;
      condPin <= cv;
      repeat (5) @(posedge clk_sys);
      blk = rows[i].exp != 16'h0000;
      chk({31'h0, ctrlBlock}, {31'h0, blk});
      chk(driveApplied, blk ? 32'h0000_0096 : 32'h1234_0040);
      chk({31'h0, faultMessage}, {31'h0, blk & i[0]});
      chk({31'h0, irq}, {31'h0, blk});
      rdchk(`CLB_ADDR_STATUS, {16'h0000, rows[i].exp});
      rdchk(`CLB_ADDR_IRQ_STAT, {16'h0000, rows[i].exp});
      condPin <= '0;
      repeat (5) @(posedge clk_sys);
      apb(1'b1, `CLB_ADDR_IRQ_STAT, 32'h0000_FFFF);
      chk({30'h0, irq, ctrlBlock}, 32'h0000_0000);
      if (blk) begin
        nBlk++;
        lastCause = rows[i].exp;
      end
    end
    rdchk(`CLB_ADDR_BLOCK_CNT, 32'(nBlk));
    rdchk(`CLB_ADDR_FIRST_CAUSE, {16'h0000, lastCause});
    $display("table test done");
    // Refusals: unmapped, read-only, illegal mode
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    apb(1'b1, `CLB_ADDR_STATUS, 32'h0000_FFFF);
    rdchk(`CLB_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, `CLB_ADDR_MODE, 32'h0000_0001);
    apb(1'b1, `CLB_ADDR_MODE, 32'h0000_0003);
    rdchk(`CLB_ADDR_MODE, 32'h0000_0001);
    $display("refusal test done");
    // Masked interrupt, new angle limit, clear while cause persists
    apb(1'b1, `CLB_ADDR_ALPHA_LIM, 32'h0000_0111);
    apb(1'b1, `CLB_ADDR_IRQ_MASK, 32'h0000_0000);
    condPin.armOverCur <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0000);
    chk(driveApplied, 32'h0000_0111);
    rdchk(`CLB_ADDR_APPLIED, 32'h0000_0111);
    rdchk(`CLB_ADDR_IRQ_STAT, 32'h0000_0001);
    apb(1'b1, `CLB_ADDR_IRQ_MASK, 32'h0000_0001);
    // New mask reaches irq one edge after the write lands
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, `CLB_ADDR_IRQ_STAT, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    chk({31'h0, ctrlBlock}, 32'h0000_0001);
    condPin <= '0;
    repeat (5) @(posedge clk_sys);
    $display("interrupt test done");
    // Second reset mid-run restores mode, angle limit, mask, block count and status
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({31'h0, ctrlBlock}, 32'h0000_0001);
    chk(driveApplied, 32'h0000_0096);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdchk(`CLB_ADDR_MODE, 32'h0000_0000);
    rdchk(`CLB_ADDR_ALPHA_LIM, 32'h0000_0096);
    rdchk(`CLB_ADDR_IRQ_MASK, 32'h0000_0000);
    rdchk(`CLB_ADDR_BLOCK_CNT, 32'h0000_0000);
    rdchk(`CLB_ADDR_STATUS, 32'h0000_0000);
    chk({31'h0, ctrlBlock}, 32'h0000_0000);
    $display("reset test done");
    report_and_stop();
  end
endmodule : clb_status_bench
